// [src/dpsc_consts.vh]
// constants for the dual pot serial command decoder
// assumes inclusion by dpsc_decoder.v only
//
// How it works
// - stored-slot read shifts slot out msb first
// - stored-slot write takes eight bits, then programs
// - status byte: zeros then write-pending flag
// - global recall loads both wipers from slot
// - global save programs, then copies both wipers at its end
// - single save copies one wiper, then programs
// - single recall loads one wiper from slot
// - stepping: direction bits until chip select rises
// - programming starts only after frame ends
// - data high steps up, low steps down
// - write-pending reads one while programming
// - commit to the slot happens when the programming timer ends
`ifndef DPSC_CONSTS_VH
`define DPSC_CONSTS_VH
// fixed prefix of the address byte; arbitrary value
`define DPSC_PREFIX 6'h2b
`define DPSC_OP_RD_SLOT 4'hb
`define DPSC_OP_WR_SLOT 4'hc
`define DPSC_OP_STATUS 4'h5
`define DPSC_OP_GRECALL 4'h1
`define DPSC_OP_GSAVE 4'h8
`define DPSC_OP_SSAVE 4'he
`define DPSC_OP_SRECALL 4'hd
`define DPSC_OP_STEP 4'h2
`define DPSC_STATUS_ARG 4'h1
`define DPSC_WIPER_RESET 8'h80
// programming time: 5 us of 200 MHz clocks
`define DPSC_PROG_CYCLES 16'h03e8
`endif

// [src/dpsc_decoder.v]
// serial command decoder for a dual pot with four stored slots per pot
// assumes sck/cs_n/si arrive from outside; sampled through two flops
`timescale 1ns/100ps
`default_nettype none
`include "dpsc_consts.vh"
module dpsc_decoder (
   // clock and reset
   input wire clock_i,
   input wire rst_n_i,
   input wire clk_en_i,
   // serial pins
   input wire sck_i,
   input wire cs_n_i,
   input wire si_i,
   output reg so_o,
   output reg so_oe_o,
   // strap address
   input wire chip_addr_hi_i,
   input wire chip_addr_lo_i,
   // wiper settings and status
   output reg [7:0] wiper0_o,
   output reg [7:0] wiper1_o,
   output reg write_pending_flag_o
);
   localparam ST_ADDR = 3'h0;
   localparam ST_OP = 3'h1;
   localparam ST_DATA = 3'h2;
   localparam ST_OUT = 3'h3;
   localparam ST_STEP = 3'h4;
   localparam ST_IGN = 3'h5;
   localparam [15:0] PROG_CYC = `DPSC_PROG_CYCLES;

   reg rst_a, rst_s;
   reg [1:0] sck_m, cs_m, si_m;
   reg [1:0] strap_m, strap_s;
   reg sck_d, cs_d;
   reg [2:0] state;
   reg [2:0] bitcnt;
   reg [7:0] shreg;
   reg [1:0] slot_sel, pot_sel;
   reg [7:0] outbyte;
   reg [7:0] slot_mem [0:7];
   reg [2:0] pend_kind; // 0 none,1 write,2 gsave,3 ssave
   reg [7:0] pend_data;
   reg [1:0] pend_slot;
   reg pend_pot;
   reg [15:0] prog_cnt;

   wire sck_rise = sck_m[1] & ~sck_d;
   wire sck_fall = ~sck_m[1] & sck_d;
   wire cs_low = ~cs_m[1];
   wire cs_rise = cs_m[1] & ~cs_d;
   wire si_s = si_m[1];
   wire [7:0] next_shreg = {shreg[6:0], si_s};
   wire [7:0] cur_wiper = pot_sel[0] ? wiper1_o : wiper0_o;

   // reset release through two flops
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_a <= 1'b0;
         rst_s <= 1'b0;
      end else begin
         rst_a <= 1'b1;
         rst_s <= rst_a;
      end
   end

   // pin synchronisers; index 0 is read only by index 1
   always @(posedge clock_i or negedge rst_s) begin
      if (!rst_s) begin
         sck_m <= 2'h0;
         cs_m <= 2'h3;
         si_m <= 2'h0;
         strap_m <= 2'h0;
         strap_s <= 2'h0;
         sck_d <= 1'b0;
         cs_d <= 1'b1;
      end else if (clk_en_i) begin
         sck_m <= {sck_m[0], sck_i};
         cs_m <= {cs_m[0], cs_n_i};
         si_m <= {si_m[0], si_i};
         strap_m <= {chip_addr_hi_i, chip_addr_lo_i};
         strap_s <= strap_m;
         sck_d <= sck_m[1];
         cs_d <= cs_m[1];
      end
   end

   // slot storage; not reset, as nonvolatile contents survive
   always @(posedge clock_i) begin
      if (clk_en_i && write_pending_flag_o && prog_cnt == 16'h0001) begin
         case (pend_kind)
            3'h1: slot_mem[{pend_pot, pend_slot}] <= pend_data;
            3'h3: slot_mem[{pend_pot, pend_slot}] <= pend_data;
            3'h2: begin
               slot_mem[{1'b0, pend_slot}] <= wiper0_o;
               slot_mem[{1'b1, pend_slot}] <= wiper1_o;
            end
            default: ;
         endcase
      end
   end

   // frame decoder, wipers and programming timer
   always @(posedge clock_i or negedge rst_s) begin
      if (!rst_s) begin
         state <= ST_ADDR;
         bitcnt <= 3'h0;
         shreg <= 8'h00;
         slot_sel <= 2'h0;
         pot_sel <= 2'h0;
         outbyte <= 8'h00;
         so_o <= 1'b0;
         so_oe_o <= 1'b0;
         wiper0_o <= `DPSC_WIPER_RESET;
         wiper1_o <= `DPSC_WIPER_RESET;
         write_pending_flag_o <= 1'b0;
         pend_kind <= 3'h0;
         pend_data <= 8'h00;
         pend_slot <= 2'h0;
         pend_pot <= 1'b0;
         prog_cnt <= 16'h0000;
      end else if (clk_en_i) begin
         // programming timer; flag tracks it
         if (write_pending_flag_o) begin
            prog_cnt <= prog_cnt - 16'h0001;
            if (prog_cnt == 16'h0001) begin
               write_pending_flag_o <= 1'b0;
               pend_kind <= 3'h0;
            end
         end
         if (!cs_low) begin
            state <= ST_ADDR;
            bitcnt <= 3'h0;
            so_oe_o <= 1'b0;
            // programming launches only on the closing edge
            if (cs_rise && pend_kind != 3'h0 && !write_pending_flag_o) begin
               write_pending_flag_o <= 1'b1;
               prog_cnt <= PROG_CYC;
            end else if (cs_rise && !write_pending_flag_o) begin
               pend_kind <= 3'h0;
            end
         end else if (sck_fall && state == ST_OUT) begin
            so_o <= outbyte[7];
            outbyte <= {outbyte[6:0], 1'b0};
            so_oe_o <= 1'b1;
         end else if (sck_rise) begin
            shreg <= next_shreg;
            bitcnt <= bitcnt + 3'h1;
            case (state)
               ST_ADDR: if (bitcnt == 3'h7) begin
                  // prefix and strap check
                  if (next_shreg[7:2] == `DPSC_PREFIX &&
                      next_shreg[1:0] == strap_s)
                     state <= ST_OP;
                  else
                     state <= ST_IGN;
               end
               ST_OP: if (bitcnt == 3'h7) begin
                  slot_sel <= next_shreg[3:2];
                  pot_sel <= next_shreg[1:0];
                  state <= ST_IGN;
                  case (next_shreg[7:4])
                     `DPSC_OP_RD_SLOT: begin
                        outbyte <= slot_mem[{next_shreg[0],
                           next_shreg[3:2]}];
                        state <= ST_OUT;
                     end
                     `DPSC_OP_STATUS:
                        if (next_shreg[3:0] == `DPSC_STATUS_ARG) begin
                           outbyte <= {7'h00, write_pending_flag_o};
                           state <= ST_OUT;
                        end
                     `DPSC_OP_WR_SLOT: state <= ST_DATA;
                     `DPSC_OP_GRECALL: begin
                        wiper0_o <= slot_mem[{1'b0, next_shreg[3:2]}];
                        wiper1_o <= slot_mem[{1'b1, next_shreg[3:2]}];
                     end
                     `DPSC_OP_SRECALL: begin
                        if (next_shreg[0])
                           wiper1_o <= slot_mem[{1'b1, next_shreg[3:2]}];
                        else
                           wiper0_o <= slot_mem[{1'b0, next_shreg[3:2]}];
                     end
                     `DPSC_OP_GSAVE: if (!write_pending_flag_o) begin
                        pend_kind <= 3'h2;
                        pend_slot <= next_shreg[3:2];
                     end
                     `DPSC_OP_SSAVE: if (!write_pending_flag_o) begin
                        pend_kind <= 3'h3;
                        pend_slot <= next_shreg[3:2];
                        pend_pot <= next_shreg[0];
                        pend_data <= next_shreg[0] ? wiper1_o : wiper0_o;
                     end
                     `DPSC_OP_STEP: state <= ST_STEP;
                     default: state <= ST_IGN;
                  endcase
               end
               ST_DATA: if (bitcnt == 3'h7) begin
                  if (!write_pending_flag_o) begin
                     pend_kind <= 3'h1;
                     pend_slot <= slot_sel;
                     pend_pot <= pot_sel[0];
                     pend_data <= next_shreg;
                  end
                  state <= ST_IGN;
               end
               ST_STEP: begin
                  // saturate at the ends of the array
                  if (si_s && cur_wiper != 8'hff) begin
                     if (pot_sel[0]) wiper1_o <= wiper1_o + 8'h01;
                     else wiper0_o <= wiper0_o + 8'h01;
                  end else if (!si_s && cur_wiper != 8'h00) begin
                     if (pot_sel[0]) wiper1_o <= wiper1_o - 8'h01;
                     else wiper0_o <= wiper0_o - 8'h01;
                  end
               end
               default: ;
            endcase
         end
      end
   end
endmodule // dpsc_decoder
`default_nettype wire

// [test/dpsc_host.sv]
// host model: drives the serial pins of the decoder
// assumes 200 MHz clock_i; sck runs at 80 ns only inside frames
`timescale 1ns/100ps
`default_nettype none
module dpsc_host (
   // clock
   input wire logic clock_i,
   // serial pins
   output var logic sck_o,
   output var logic cs_n_o,
   output var logic si_o,
   input wire logic so_i
);
   // idle pins before the first frame
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
   end
   // n bits msb first; so sampled just before each rise
   task automatic shift(input logic [7:0] tx, input int n,
                        inout logic [7:0] rx);
      for (int i = 0; i < n; i++) begin
         si_o <= tx[7-i];
         repeat (8) @(posedge clock_i);
         rx = {rx[6:0], so_i};
         sck_o <= 1'b1;
         repeat (8) @(posedge clock_i);
         sck_o <= 1'b0;
      end
   endtask
   // address, opcode, then n data bits
   task automatic frame(input logic [7:0] adr, op, dat, input int n,
                        inout logic [7:0] rx);
      cs_n_o <= 1'b0;
      repeat (4) @(posedge clock_i);
      shift(adr, 8, rx);
      shift(op, 8, rx);
      if (n > 0) shift(dat, n, rx);
      repeat (8) @(posedge clock_i);
      cs_n_o <= 1'b1;
      si_o <= ~si_o; // released line must not keep its last level
      repeat (10) @(posedge clock_i);
   endtask
endmodule // dpsc_host
`default_nettype wire

// [test/dpsc_decoder_assertions.sv]
// port checker for the serial command decoder
// assumes clk_en_i stays high while checked
`timescale 1ns/100ps
`default_nettype none
module dpsc_checker (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // serial pins
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic so_o,
   input wire logic so_oe_o,
   // outputs
   input wire logic [7:0] wiper0_o,
   input wire logic [7:0] wiper1_o,
   input wire logic write_pending_flag_o
);
   logic [10:0] prog_cnt;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // length of the running programming pulse
   always @(posedge clock_i or negedge rst_n_i)
      if (!rst_n_i) prog_cnt <= 11'h000;
      else prog_cnt <= write_pending_flag_o ? prog_cnt + 11'h001 : 11'h000;
   sequence cs_idle;
      cs_n_i [*6];
   endsequence
   oe_off_a: assert property (cs_idle |-> !so_oe_o)
      else $error("so driven outside a frame");
   oe_start_a: assert property ($rose(so_oe_o) |->
      !$past(cs_n_i, 3) && !$past(sck_i, 3))
      else $error("so enabled without a falling sck");
   prog_after_a: assert property ($rose(write_pending_flag_o) |->
      $past(cs_n_i, 1) && $past(cs_n_i, 2))
      else $error("programming began inside a frame");
   prog_len_a: assert property ($fell(write_pending_flag_o) |->
      prog_cnt == 11'h3e8)
      else $error("programming pulse length wrong");
   prog_max_a: assert property (prog_cnt <= 11'h3e8)
      else $error("programming pulse too long");
   so_hold_a: assert property (sck_i [*4] |-> $stable(so_o))
      else $error("so moved while sck high");
   wiper0_cause_a: assert property ($changed(wiper0_o) |->
      !$past(cs_n_i, 3))
      else $error("wiper 0 moved outside a frame");
   wiper1_cause_a: assert property ($changed(wiper1_o) |->
      !$past(cs_n_i, 3))
      else $error("wiper 1 moved outside a frame");
endmodule // dpsc_checker
bind dpsc_decoder dpsc_checker dpsc_checker_i (.clock_i(clock_i),
   .rst_n_i(rst_n_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .so_o(so_o),
   .so_oe_o(so_oe_o), .wiper0_o(wiper0_o), .wiper1_o(wiper1_o),
   .write_pending_flag_o(write_pending_flag_o));
`default_nettype wire

// [test/dual_pot_serial_command_decoder_test.sv]
// self-checking bench for the serial command decoder
// assumes the host model and checker files compile first
`timescale 1ns/100ps
`default_nettype none
module dual_pot_serial_command_decoder_test;
   logic clock_i, rst_n_i, sck, cs_n, si, so, so_oe, flag;
   logic [7:0] w0, w1;
   logic [7:0] rx = 8'h00;
   int num_errors = 0;
   int tests_run = 0;
   logic so_line;
   logic clk_en = 1'b1;
   int oe_cycles = 0;
   // released so line shows the inverse of its last level
   assign so_line = so_oe ? so : ~so;
   // cycles in which the decoder drives so
   always @(posedge clock_i)
      if (so_oe === 1'b1) oe_cycles <= oe_cycles + 1;
   // 200 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   // straps fixed at address 1,0
   dpsc_decoder dpsc_decoder_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .clk_en_i(clk_en), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so),
      .so_oe_o(so_oe), .chip_addr_hi_i(1'b1), .chip_addr_lo_i(1'b0),
      .wiper0_o(w0), .wiper1_o(w1), .write_pending_flag_o(flag));
   dpsc_host dpsc_host_i (.clock_i(clock_i), .sck_o(sck), .cs_n_o(cs_n),
      .si_o(si), .so_i(so_line));
   task automatic chk(input logic [7:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] op, dat, input int n);
      // address byte: fixed prefix, straps 1,0
      dpsc_host_i.frame(8'hae, op, dat, n, rx);
   endtask
   // bounded wait for the programming pulse to end
   task automatic wait_idle;
      for (int i = 0; i < 2000 && flag !== 1'b0; i++) @(posedge clock_i);
      if (flag !== 1'b0) begin
         num_errors++;
         end_of_test;
      end
   endtask
   task automatic t_write_read;
      cmd(8'hc9, 8'ha5, 8);
      chk(flag, 8'h01);
      cmd(8'h51, 8'h00, 8);
      chk(rx, 8'h01);
      // a write while programming runs is dropped
      cmd(8'hc9, 8'h3c, 8);
      chk(flag, 8'h01);
      wait_idle;
      cmd(8'h51, 8'h00, 8);
      chk(rx, 8'h00);
      cmd(8'hb9, 8'h00, 8);
      chk(rx, 8'ha5);
   endtask
   task automatic t_foreign;
      int oe_base = oe_cycles;
      dpsc_host_i.frame(8'haf, 8'hc9, 8'h3c, 8, rx);
      dpsc_host_i.frame(8'h72, 8'hc9, 8'h3c, 8, rx);
      dpsc_host_i.frame(8'haf, 8'hb9, 8'h00, 8, rx);
      chk(flag, 8'h00);
      chk(8'(oe_cycles - oe_base), 8'h00);
      cmd(8'hb9, 8'h00, 8);
      chk(rx, 8'ha5);
   endtask
   task automatic t_recall_step;
      cmd(8'hd9, 8'h00, 0);
      chk(w1, 8'ha5);
      chk(w0, 8'h80);
      cmd(8'h20, 8'he0, 8);
      chk(w0, 8'h7e);
      // a frame sent while the clock enable is low leaves no trace
      clk_en <= 1'b0;
      cmd(8'h20, 8'hff, 8);
      chk(w0, 8'h7e);
      clk_en <= 1'b1;
   endtask
   task automatic t_saves;
      cmd(8'he4, 8'h00, 0);
      wait_idle;
      cmd(8'hb4, 8'h00, 8);
      chk(rx, 8'h7e);
      cmd(8'h8c, 8'h00, 0);
      wait_idle;
      cmd(8'h21, 8'h00, 4);
      chk(w1, 8'ha1);
      cmd(8'h1c, 8'h00, 0);
      chk(w0, 8'h7e);
      chk(w1, 8'ha5);
   endtask
   // reset, then the scenarios in order
   initial begin
      rst_n_i = 1'b0;
      repeat (10) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (6) @(posedge clock_i);
      chk(w0, 8'h80);
      chk({so_oe, flag}, 8'h00);
      t_write_read;
      t_foreign;
      t_recall_step;
      t_saves;
      end_of_test;
   end
endmodule // dual_pot_serial_command_decoder_test
`default_nettype wire
